// File: src/qrr_pkg.sv
// qrr_pkg: query addresses, answer layout, timing and state encodings
// assumes a byte-wide command link and a byte-wide calibration memory port
package qrr_pkg;
   // query register addresses
   localparam logic [7:0] TEMPERATURE_QUERY_ADDR       = 8'h31;
   localparam logic [7:0] OPERATING_STATUS_QUERY_ADDR  = 8'h32;
   localparam logic [7:0] DEVICE_INFORMATION_QUERY_ADDR = 8'h33;
   localparam logic [7:0] CALIBRATION_MEMORY_QUERY_ADDR = 8'h35;

   // answer length and parameter counts
   localparam int unsigned ANSWER_BYTES     = 8;
   localparam int unsigned SHORT_QUERY_BYTES = 2;
   localparam int unsigned CAL_QUERY_BYTES  = 3;
   localparam logic [2:0]  LAST_BYTE_IDX    = 3'h7;

   // status word field positions
   localparam int unsigned ST_LOCK_LSB      = 0;
   localparam int unsigned ST_TCXO_LOCK     = 6;
   localparam int unsigned ST_REF_DETECT    = 7;
   localparam int unsigned ST_ACCESSED      = 8;
   localparam int unsigned ST_EXT_LOCK_EN   = 9;
   localparam int unsigned ST_REF_OUT_EN    = 10;
   localparam int unsigned ST_REF_FREQ_SEL  = 11;
   localparam int unsigned ST_SYNTH_PWR_LSB = 12;
   localparam int unsigned ST_LOOP_GAIN_LSB = 15;
   localparam int unsigned ST_FAST_TUNE     = 17;
   localparam int unsigned ST_OSC_TO_PORT   = 18;
   localparam int unsigned ST_SC_POWERED    = 24;
   localparam int unsigned ST_CONV_BYPASS   = 25;
   localparam int unsigned ST_EXT_IF2_SEL   = 26;
   localparam int unsigned ST_IF3_BYPASS    = 27;
   localparam int unsigned ST_IF2_FILTER    = 29;
   localparam int unsigned ST_BANK1_LSB     = 30;
   localparam int unsigned ST_BANK2         = 32;
   localparam int unsigned ST_AUTO_GAIN     = 35;
   localparam int unsigned ST_AUTO_RF_FILT  = 37;

   // info selector codes
   localparam logic [3:0] INFO_SERIAL_IF = 4'h0;
   localparam logic [3:0] INFO_HW_REV    = 4'h1;
   localparam logic [3:0] INFO_FW_REV    = 4'h2;
   localparam logic [3:0] INFO_IF        = 4'h3;
   localparam logic [3:0] INFO_MFG_DATE  = 4'h4;
   localparam logic [3:0] INFO_CAL_DATE  = 4'h5;

   // synchroniser depth for asynchronous status pins
   localparam int unsigned SYNC_STAGES = 3;
   localparam logic [63:0] ANSWER_RESET = 64'h0;

   typedef enum logic [5:0] {
      QRR_IDLE    = 6'b000001,
      QRR_PARAM   = 6'b000010,
      QRR_PARAM2  = 6'b000100,
      QRR_MEMRD   = 6'b001000,
      QRR_LOAD    = 6'b010000,
      QRR_ANSWER  = 6'b100000
   } qrr_state_t;
endpackage

// File: src/qrr_sync.sv
// qrr_sync: three-stage synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to core_clk
`timescale 1ns/10ps
module qrr_sync (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic pin_in,
   output logic      level_out
);
   logic [2:0] stage_reg;
   logic [2:0] stage_next;
   logic       level_reg;
   logic       level_next;

   always_comb begin
      stage_next = {stage_reg[1:0], pin_in};
      // change taken once stages two and three agree
      level_next = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : level_reg;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         stage_reg <= 3'h0;
         level_reg <= 1'b0;
      end else begin
         stage_reg <= stage_next;
         level_reg <= level_next;
      end
   end

   assign level_out = level_reg;
endmodule

// File: src/qrr_mem_reader.sv
// qrr_mem_reader: fetches eight bytes from the calibration memory
// assumes a byte memory port answering one cycle after each request
`timescale 1ns/10ps
module qrr_mem_reader (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        start,
   input  wire logic [15:0] start_addr,
   output logic             mem_rd_en,
   output logic [15:0]      mem_addr,
   input  wire logic [7:0]  mem_rd_data,
   output logic             done,
   output logic [63:0]      data_out
);
   logic [3:0]  cnt_reg;
   logic [3:0]  cnt_next;
   logic        busy_reg;
   logic        busy_next;
   logic        pend_reg;
   logic        pend_next;
   logic [2:0]  slot_reg;
   logic [2:0]  slot_next;
   logic [15:0] addr_reg;
   logic [15:0] addr_next;
   logic [63:0] data_reg;
   logic [63:0] data_next;
   logic        done_reg;
   logic        done_next;

   always_comb begin
      cnt_next  = cnt_reg;
      busy_next = busy_reg;
      addr_next = addr_reg;
      data_next = data_reg;
      pend_next = 1'b0;
      slot_next = cnt_reg[2:0];
      done_next = 1'b0;
      if (start) begin
         busy_next = 1'b1;
         cnt_next  = 4'h0;
         addr_next = start_addr;
         data_next = 64'h0;
      end else if (busy_reg) begin
         pend_next = 1'b1;
         addr_next = addr_reg + 16'h1;
         cnt_next  = cnt_reg + 4'h1;
         if (cnt_reg == 4'h7)
            busy_next = 1'b0;
      end
      // start byte lands lowest, later bytes higher
      if (pend_reg)
         data_next[slot_reg*8 +: 8] = mem_rd_data;
      if (pend_reg && slot_reg == 3'h7)
         done_next = 1'b1;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_reg  <= 4'h0;
         busy_reg <= 1'b0;
         pend_reg <= 1'b0;
         slot_reg <= 3'h0;
         addr_reg <= 16'h0;
         data_reg <= 64'h0;
         done_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         busy_reg <= busy_next;
         pend_reg <= pend_next;
         slot_reg <= slot_next;
         addr_reg <= addr_next;
         data_reg <= data_next;
         done_reg <= done_next;
      end
   end

   assign mem_rd_en = busy_reg;
   assign mem_addr  = addr_reg;
   assign done      = done_reg;
   assign data_out  = data_reg;
endmodule

// File: src/qrr_top.sv
// qrr_top: query register responder behind the byte command link
// assumes link bytes arrive as valid/ready pairs on core_clk
// Summary of operation
// - host writes address and parameters, then reads answer; device prepares it.
// - answers are eight bytes, most significant first, all read by host.
// - temperature, status, info queries take two bytes, give eight.
// - address 0x31 captures current temperature for next readback.
// - temperature float in bits 31:0; upper 32 bits invalid.
// - address 0x32 snapshots current operating conditions.
// - bits 0 to 5 report the oscillator loop locks.
// - bit 6 reports reference oscillator lock, valid with external lock.
// - bit 7 reports a detected reference of sufficient amplitude.
// - bit 8 set once system-active configuration was accessed.
// - bits 9 to 11 mirror reference lock, output enable, frequency.
// - bits 16:15 loop gain; bits 12 to 14 synthesizer power.
// - bit 17 reports first oscillator fast-tune mode.
// - bit 18 reports first oscillator routed to output port.
// - bit 24 reports signal chain powered.
// - bits 25 to 27 report signal-chain routing and bypasses.
// - bit 29 reports second-IF filter, 0 is 160, 1 is 80 MHz.
// - bits 31:30 filter bank one, bit 32 filter bank two.
// - bit 35 reports automatic gain calculation enable.
// - bit 37 reports automatic RF filter selection.
// - info selector in bits 3:0 picks serial, revisions, interface, dates.
// - address 0x35 takes 16-bit start, reads eight calibration bytes.
// - byte at start address becomes least significant answer byte.
`timescale 1ns/10ps
module qrr_top (
   input  wire logic        core_clk,
   input  wire logic        rst,
   // command link, host to device
   input  wire logic        cmd_valid,
   input  wire logic [7:0]  cmd_data,
   output logic             cmd_ready,
   // answer link, device to host
   output logic             rsp_valid,
   output logic [7:0]       rsp_data,
   input  wire logic        rsp_ready,
   // temperature sensor word, same clock
   input  wire logic [31:0] temperature_word,
   // asynchronous lock and detect pins
   input  wire logic [5:0]  osc_lock_pins,
   input  wire logic        tcxo_lock_pin,
   input  wire logic        ref_detect_pin,
   // configuration levels, same clock
   input  wire logic        system_active_config,
   input  wire logic        external_ref_lock_en,
   input  wire logic        ref_output_en,
   input  wire logic        ref_output_freq_sel,
   input  wire logic        first_synth_powered,
   input  wire logic        second_synth_powered,
   input  wire logic        third_synth_powered,
   input  wire logic [1:0]  synth_loop_gain,
   input  wire logic        fast_tune_flag,
   input  wire logic        first_osc_to_port,
   input  wire logic        signal_chain_powered,
   input  wire logic        conversion_bypass,
   input  wire logic        external_second_if_sel,
   input  wire logic        third_if_conv_bypass,
   input  wire logic        second_if_filter_sel,
   input  wire logic [1:0]  if3_bank1_sel,
   input  wire logic        if3_bank2_sel,
   input  wire logic        auto_gain_calc_en,
   input  wire logic        auto_rf_filter_sel,
   // identity records, same clock
   input  wire logic [31:0] serial_number,
   input  wire logic [7:0]  interface_type,
   input  wire logic [31:0] hw_revision,
   input  wire logic [31:0] fw_revision,
   input  wire logic [31:0] mfg_date,
   input  wire logic [31:0] cal_date,
   // calibration memory port
   output logic             cal_rd_en,
   output logic [15:0]      cal_addr,
   input  wire logic [7:0]  cal_rd_data
);
   qrr_pkg::qrr_state_t state_reg;
   qrr_pkg::qrr_state_t state_next;
   logic [7:0]  addr_reg;
   logic [7:0]  addr_next;
   logic [7:0]  par_lo_reg;
   logic [7:0]  par_lo_next;
   logic [63:0] answer_reg;
   logic [63:0] answer_next;
   logic [2:0]  idx_reg;
   logic [2:0]  idx_next;
   logic [7:0]  rsp_data_reg;
   logic [7:0]  rsp_data_next;
   logic        accessed_reg;
   logic        accessed_next;
   logic        mem_start;
   logic        mem_done;
   logic [63:0] mem_word;
   logic [5:0]  osc_lock_s;
   logic        tcxo_lock_s;
   logic        ref_detect_s;
   logic [63:0] status_word;
   logic [63:0] info_word;

   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_lock
         qrr_sync u_sync (
            .core_clk  (core_clk),
            .rst       (rst),
            .pin_in    (osc_lock_pins[g]),
            .level_out (osc_lock_s[g])
         );
      end
   endgenerate

   qrr_sync u_tcxo_sync (
      .core_clk  (core_clk),
      .rst       (rst),
      .pin_in    (tcxo_lock_pin),
      .level_out (tcxo_lock_s)
   );

   qrr_sync u_det_sync (
      .core_clk  (core_clk),
      .rst       (rst),
      .pin_in    (ref_detect_pin),
      .level_out (ref_detect_s)
   );

   qrr_mem_reader u_mem (
      .core_clk    (core_clk),
      .rst         (rst),
      .start       (mem_start),
      .start_addr  ({par_lo_reg, cmd_data}),
      .mem_rd_en   (cal_rd_en),
      .mem_addr    (cal_addr),
      .mem_rd_data (cal_rd_data),
      .done        (mem_done),
      .data_out    (mem_word)
   );

   // status snapshot, unlisted bits zero
   always_comb begin
      status_word = 64'h0;
      status_word[qrr_pkg::ST_LOCK_LSB +: 6] = osc_lock_s;
      status_word[qrr_pkg::ST_TCXO_LOCK] =
         tcxo_lock_s & external_ref_lock_en;
      status_word[qrr_pkg::ST_REF_DETECT] = ref_detect_s;
      status_word[qrr_pkg::ST_ACCESSED] = accessed_reg;
      status_word[qrr_pkg::ST_EXT_LOCK_EN] = external_ref_lock_en;
      status_word[qrr_pkg::ST_REF_OUT_EN] = ref_output_en;
      status_word[qrr_pkg::ST_REF_FREQ_SEL] = ref_output_freq_sel;
      status_word[qrr_pkg::ST_SYNTH_PWR_LSB +: 3] = {third_synth_powered,
         second_synth_powered, first_synth_powered};
      status_word[qrr_pkg::ST_LOOP_GAIN_LSB +: 2] = synth_loop_gain;
      status_word[qrr_pkg::ST_FAST_TUNE] = fast_tune_flag;
      status_word[qrr_pkg::ST_OSC_TO_PORT] = first_osc_to_port;
      status_word[qrr_pkg::ST_SC_POWERED] = signal_chain_powered;
      status_word[qrr_pkg::ST_CONV_BYPASS] = conversion_bypass;
      status_word[qrr_pkg::ST_EXT_IF2_SEL] = external_second_if_sel;
      status_word[qrr_pkg::ST_IF3_BYPASS] = third_if_conv_bypass;
      status_word[qrr_pkg::ST_IF2_FILTER] = second_if_filter_sel;
      status_word[qrr_pkg::ST_BANK1_LSB +: 2] = if3_bank1_sel;
      status_word[qrr_pkg::ST_BANK2] = if3_bank2_sel;
      status_word[qrr_pkg::ST_AUTO_GAIN] = auto_gain_calc_en;
      status_word[qrr_pkg::ST_AUTO_RF_FILT] = auto_rf_filter_sel;
   end

   // info record by selector, undefined selectors answer zero
   always_comb begin
      unique case (cmd_data[3:0])
         qrr_pkg::INFO_SERIAL_IF: info_word = {24'h0, interface_type,
                                               serial_number};
         qrr_pkg::INFO_HW_REV:    info_word = {32'h0, hw_revision};
         qrr_pkg::INFO_FW_REV:    info_word = {fw_revision, 32'h0};
         qrr_pkg::INFO_IF:        info_word = {24'h0, interface_type, 32'h0};
         qrr_pkg::INFO_MFG_DATE:  info_word = {32'h0, mfg_date};
         qrr_pkg::INFO_CAL_DATE:  info_word = {cal_date, 32'h0};
         default:                 info_word = 64'h0;
      endcase
   end

   // command sequencer and answer shifter
   always_comb begin
      state_next    = state_reg;
      addr_next     = addr_reg;
      par_lo_next   = par_lo_reg;
      answer_next   = answer_reg;
      idx_next      = idx_reg;
      rsp_data_next = rsp_data_reg;
      accessed_next = accessed_reg | system_active_config;
      mem_start     = 1'b0;
      cmd_ready     = 1'b0;
      rsp_valid     = 1'b0;
      unique case (state_reg)
         qrr_pkg::QRR_IDLE: begin
            cmd_ready = 1'b1;
            if (cmd_valid) begin
               addr_next  = cmd_data;
               state_next = qrr_pkg::QRR_PARAM;
            end
         end
         qrr_pkg::QRR_PARAM: begin
            cmd_ready = 1'b1;
            if (cmd_valid) begin
               state_next = qrr_pkg::QRR_LOAD;
               unique case (addr_reg)
                  qrr_pkg::TEMPERATURE_QUERY_ADDR:
                     answer_next = {32'h0, temperature_word};
                  qrr_pkg::OPERATING_STATUS_QUERY_ADDR:
                     answer_next = status_word;
                  qrr_pkg::DEVICE_INFORMATION_QUERY_ADDR:
                     answer_next = info_word;
                  qrr_pkg::CALIBRATION_MEMORY_QUERY_ADDR: begin
                     par_lo_next = cmd_data;
                     state_next  = qrr_pkg::QRR_PARAM2;
                  end
                  default: begin
                     answer_next = qrr_pkg::ANSWER_RESET;
                     state_next  = qrr_pkg::QRR_IDLE;
                  end
               endcase
            end
         end
         qrr_pkg::QRR_PARAM2: begin
            cmd_ready = 1'b1;
            if (cmd_valid) begin
               // high address byte first, then low
               mem_start  = 1'b1;
               state_next = qrr_pkg::QRR_MEMRD;
            end
         end
         qrr_pkg::QRR_MEMRD: begin
            if (mem_done) begin
               answer_next = mem_word;
               state_next  = qrr_pkg::QRR_LOAD;
            end
         end
         qrr_pkg::QRR_LOAD: begin
            idx_next      = 3'h0;
            rsp_data_next = answer_reg[63:56];
            state_next    = qrr_pkg::QRR_ANSWER;
         end
         qrr_pkg::QRR_ANSWER: begin
            rsp_valid = 1'b1;
            if (rsp_ready) begin
               answer_next   = {answer_reg[55:0], 8'h0};
               rsp_data_next = answer_reg[55:48];
               idx_next      = idx_reg + 3'h1;
               if (idx_reg == qrr_pkg::LAST_BYTE_IDX)
                  state_next = qrr_pkg::QRR_IDLE;
            end
         end
         default: state_next = qrr_pkg::QRR_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg    <= qrr_pkg::QRR_IDLE;
         addr_reg     <= 8'h0;
         par_lo_reg   <= 8'h0;
         answer_reg   <= qrr_pkg::ANSWER_RESET;
         idx_reg      <= 3'h0;
         rsp_data_reg <= 8'h0;
         accessed_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;
         addr_reg     <= addr_next;
         par_lo_reg   <= par_lo_next;
         answer_reg   <= answer_next;
         idx_reg      <= idx_next;
         rsp_data_reg <= rsp_data_next;
         accessed_reg <= accessed_next;
      end
   end

   assign rsp_data = rsp_data_reg;
endmodule

// File: test/qrr_checker.sv
// qrr_checker: port-level assertions for qrr_top
// assumes one clock domain with asynchronous active-high reset
`timescale 1ns/10ps
module qrr_checker (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        cmd_valid,
   input wire logic [7:0]  cmd_data,
   input wire logic        cmd_ready,
   input wire logic        rsp_valid,
   input wire logic [7:0]  rsp_data,
   input wire logic        rsp_ready,
   input wire logic        cal_rd_en,
   input wire logic [15:0] cal_addr
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   wire take = cmd_valid && cmd_ready;
   sequence s_short(a);
      // address byte only: the cycle before holds no take
      !$past(take) && take && cmd_data == a ##1 take;
   endsequence
   sequence s_cal;
      take && cmd_data == qrr_pkg::CALIBRATION_MEMORY_QUERY_ADDR ##1 take
      ##1 take;
   endsequence
   temp_upper_a: assert property (
      s_short(qrr_pkg::TEMPERATURE_QUERY_ADDR) |->
      ##2 rsp_valid && rsp_data == 8'h00)
      else $error("temperature answer late or upper byte nonzero");
   status_upper_a: assert property (
      s_short(qrr_pkg::OPERATING_STATUS_QUERY_ADDR) |->
      ##2 rsp_valid && rsp_data == 8'h00)
      else $error("status answer late or upper byte nonzero");
   cal_start_a: assert property (
      s_cal |=> cal_rd_en && cal_addr == {$past(cmd_data, 2), $past(cmd_data)})
      else $error("calibration fetch start address wrong");
   cal_burst_a: assert property (
      $rose(cal_rd_en) |-> cal_rd_en [*8] ##1 !cal_rd_en)
      else $error("calibration fetch not eight reads");
   cal_incr_a: assert property (
      cal_rd_en && $past(cal_rd_en) |-> cal_addr == $past(cal_addr) + 16'h1)
      else $error("calibration address not incrementing");
   cal_answer_a: assert property (
      s_cal |-> ##[1:16] rsp_valid)
      else $error("calibration answer missing");
   rsp_hold_a: assert property (
      rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
      else $error("answer byte dropped or changed while stalled");
   rsp_drop_a: assert property (
      $fell(rsp_valid) |-> $past(rsp_ready))
      else $error("answer withdrawn without host take");
   busy_refuse_a: assert property (
      rsp_valid || cal_rd_en |-> !cmd_ready)
      else $error("command accepted while answer pending");
endmodule
bind qrr_top qrr_checker u_qrr_checker (
   .core_clk, .rst, .cmd_valid, .cmd_data, .cmd_ready, .rsp_valid,
   .rsp_data, .rsp_ready, .cal_rd_en, .cal_addr
);

// File: test/qrr_cal_mem_model.sv
// qrr_cal_mem_model: calibration memory behind the byte read port
// assumes data is due one cycle after each requested address
`timescale 1ns/10ps
module qrr_cal_mem_model (
   input  wire logic        core_clk,
   input  wire logic        cal_rd_en,
   input  wire logic [15:0] cal_addr,
   output logic [7:0]       cal_rd_data
);
   initial cal_rd_data = 8'h00;
   // idle cycles scramble the bus so stale data is not reused
   always @(posedge core_clk)
      if (cal_rd_en) cal_rd_data <= cal_addr[7:0] ^ cal_addr[15:8] ^ 8'h5a;
      else cal_rd_data <= ~cal_rd_data;
endmodule

// File: test/testbench.sv
// testbench: directed and random queries against qrr_top
// assumes qrr_cal_mem_model on the calibration port
`timescale 1ns/10ps
module testbench;
   logic        core_clk, rst, cmd_valid, rsp_ready, sys_act;
   logic        cmd_ready, rsp_valid, cal_rd_en;
   logic [7:0]  cmd_data, iface, cal_rd_data, rsp_data;
   logic [15:0] cal_addr;
   logic [31:0] temp_w, serial, hwr, fwr, mfgd, cald;
   logic [5:0]  osc;
   logic [21:0] cfg;
   logic [7:0]  expq[$];
   int          error_cnt, tests_run, took, cyc;
   int          sels[8] = '{0, 1, 2, 3, 4, 5, 6, 15};
   logic [15:0] starts[3] = '{16'h0000, 16'hfffd, 16'h12a7};

   qrr_top u_qrr_top (
      .core_clk, .rst, .cmd_valid, .cmd_data, .cmd_ready, .rsp_valid,
      .rsp_data, .rsp_ready, .temperature_word(temp_w),
      .osc_lock_pins(osc), .tcxo_lock_pin(cfg[0]), .ref_detect_pin(cfg[1]),
      .system_active_config(sys_act), .external_ref_lock_en(cfg[2]),
      .ref_output_en(cfg[3]), .ref_output_freq_sel(cfg[4]),
      .first_synth_powered(cfg[5]), .second_synth_powered(cfg[6]),
      .third_synth_powered(cfg[7]), .synth_loop_gain(cfg[9:8]),
      .fast_tune_flag(cfg[10]), .first_osc_to_port(cfg[11]),
      .signal_chain_powered(cfg[12]), .conversion_bypass(cfg[13]),
      .external_second_if_sel(cfg[14]), .third_if_conv_bypass(cfg[15]),
      .second_if_filter_sel(cfg[16]), .if3_bank1_sel(cfg[18:17]),
      .if3_bank2_sel(cfg[19]), .auto_gain_calc_en(cfg[20]),
      .auto_rf_filter_sel(cfg[21]), .serial_number(serial),
      .interface_type(iface), .hw_revision(hwr), .fw_revision(fwr),
      .mfg_date(mfgd), .cal_date(cald), .cal_rd_en, .cal_addr, .cal_rd_data
   );
   qrr_cal_mem_model u_qrr_cal_mem_model (
      .core_clk, .cal_rd_en, .cal_addr, .cal_rd_data
   );

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   task automatic chk8(input string what, input logic [7:0] e, g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // called at a falling edge, returns at the falling edge after the take
   task automatic send(input logic [7:0] b);
      cmd_valid = 1'b1;
      cmd_data = b;
      while (cmd_ready !== 1'b1) @(negedge core_clk);
      @(negedge core_clk);
   endtask

   task automatic query(input logic [7:0] a, input logic [15:0] p,
                        input logic [63:0] e);
      send(a);
      if (a == 8'h35) send(p[15:8]);
      send(p[7:0]);
      cmd_valid = 1'b0;
      cmd_data = ~cmd_data;
      for (int k = 7; k >= 0; k--) expq.push_back(e[8*k +: 8]);
      took = 0;
      while (took < 8) begin
         @(negedge core_clk);
         rsp_ready = ($urandom % 3) != 0;
      end
      @(negedge core_clk);
      rsp_ready = 1'b0;
   endtask

   function automatic logic [63:0] status_exp(input logic acc);
      status_exp = 64'h0;
      status_exp[8:0] = {acc, cfg[1], cfg[0] & cfg[2], osc};
      status_exp[18:9] = {cfg[11:8], cfg[7:2]};
      status_exp[37:24] = {cfg[21], 1'b0, cfg[20], 2'b0,
                           cfg[19:16], 1'b0, cfg[15:12]};
   endfunction

   function automatic logic [63:0] info_exp(input logic [3:0] s);
      case (s)
         4'h0: info_exp = {24'h0, iface, serial};
         4'h1: info_exp = {32'h0, hwr};
         4'h2: info_exp = {fwr, 32'h0};
         4'h3: info_exp = {24'h0, iface, 32'h0};
         4'h4: info_exp = {32'h0, mfgd};
         4'h5: info_exp = {cald, 32'h0};
         default: info_exp = 64'h0;
      endcase
   endfunction

   function automatic logic [63:0] cal_exp(input logic [15:0] s);
      logic [15:0] a;
      for (int i = 0; i < 8; i++) begin
         a = s + 16'(i);
         cal_exp[8*i +: 8] = a[7:0] ^ a[15:8] ^ 8'h5a;
      end
   endfunction

   // answer watcher and hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         end_of_test();
      end
      if (rst === 1'b0 && rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
         took++;
         if (expq.size() == 0) chk8("answer length", 8'h00, 8'h01);
         else chk8("rsp_data", expq.pop_front(), rsp_data);
      end
   end

   initial begin
      void'($urandom(91));
      {cmd_valid, rsp_ready, sys_act, cmd_data} = '0;
      {temp_w, serial, hwr, fwr, mfgd, cald, iface, osc, cfg} = '0;
      rst = 1'b1;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      chk8("reset outputs", 8'h04, {5'h0, cmd_ready, rsp_valid, cal_rd_en});
      rst = 1'b0;
      for (int i = 0; i < 3; i++) begin
         temp_w = $urandom;
         query(8'h31, 16'h0, {32'h0, temp_w});
      end
      $display("test temperature done");
      for (int i = 0; i < 4; i++) begin
         cfg = 22'($urandom);
         osc = 6'($urandom);
         if (i == 1) sys_act = 1'b1;
         if (i == 2) cfg[2:0] = 3'b011;
         repeat (6) @(negedge core_clk);
         sys_act = 1'b0;
         query(8'h32, 16'h0, status_exp(i > 0));
      end
      $display("test status done");
      {serial, hwr, fwr} = {$urandom, $urandom, $urandom};
      {mfgd, cald, iface} = {$urandom, $urandom, 8'($urandom)};
      foreach (sels[i]) query(8'h33, 16'(sels[i]), info_exp(4'(sels[i])));
      $display("test information done");
      foreach (starts[i]) query(8'h35, starts[i], cal_exp(starts[i]));
      $display("test calibration done");
      send(8'h34);
      send(8'h00);
      cmd_valid = 1'b0;
      rsp_ready = 1'b1;
      repeat (10) @(negedge core_clk);
      rsp_ready = 1'b0;
      chk8("ready after unknown", 8'h01, {7'h0, cmd_ready});
      $display("test unknown address done");
      rst = 1'b1;
      @(negedge core_clk);
      rst = 1'b0;
      cfg = 22'($urandom);
      repeat (6) @(negedge core_clk);
      query(8'h32, 16'h0, status_exp(1'b0));
      $display("test second reset done");
      end_of_test();
   end
endmodule
